// ==== buck_rail_mode_voltage_regs.sv ====
`timescale 1ns/1ps
module buck_rail_mode_voltage_regs
	import rail_regs_pkg::*;
(
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [ADDR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic                standby_request_n_i,
	output rail_status_t             rail_1v2_o,
	output rail_status_t             rail_1v0_o
);

	// ****************************************
	// Decode helpers
	// ****************************************
	// 01 and 10 are both auto mode
	function automatic conv_mode_t decode_mode(input logic [1:0] code);
		conv_mode_t m;
		case (code)
			2'b00: m = CONV_OFF;
			2'b11: m = CONV_PWM;
			default: m = CONV_AUTO;
		endcase
		return m;
	endfunction

	// Code 00 keeps mode, else the code is loaded
	function automatic logic [7:0] exit_rewrite(input logic [7:0] r);
		logic [7:0] v;
		v = r;
		if (r[EXIT_LSB+:2] != 2'b00) begin
			v[MODE_LSB+:2] = r[EXIT_LSB+:2];
		end
		return v;
	endfunction

	// One percent per step, lowest code highest voltage
	function automatic trim_t trim_1v2(input logic [2:0] code);
		trim_t t;
		case (code)
			3'h0: t = 8'sd30;
			3'h1: t = 8'sd20;
			3'h2: t = 8'sd10;
			3'h3: t = 8'sd0;
			3'h4: t = -8'sd10;
			3'h5: t = -8'sd20;
			3'h6: t = -8'sd30;
			default: t = -8'sd40;
		endcase
		return t;
	endfunction

	// 1.05 V, 1.0 V, 0.975 V, 0.95 V
	function automatic trim_t trim_1v0(input logic [1:0] code);
		trim_t t;
		case (code)
			2'h0: t = 8'sd50;
			2'h1: t = 8'sd0;
			2'h2: t = -8'sd25;
			default: t = -8'sd50;
		endcase
		return t;
	endfunction

	// Only lane 0 carries the byte; upper lanes are ignored
	function automatic logic [7:0] merge_byte(input logic [7:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [7:0] v;
		v = sel[0] ? dat[7:0] : old;
		return v;
	endfunction

	// ****************************************
	// State
	// ****************************************
	// Whole module state lives in one struct
	regs_state_t st_ff;
	regs_state_t nxt_st;

	logic bus_req;
	logic in_standby;
	logic exit_edge;

	// New request only while not already acknowledging
	assign bus_req    = wb_cyc_i & wb_stb_i & ~st_ff.ack;
	assign in_standby = ~st_ff.stby_sync;
	// Sync and prev park high, so reset gives no false exit edge
	assign exit_edge  = st_ff.stby_sync & ~st_ff.stby_prev;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.stby_meta = standby_request_n_i;
		nxt_st.stby_sync = st_ff.stby_meta;
		nxt_st.stby_prev = st_ff.stby_sync;
		nxt_st.ack = bus_req;
		// Standby exit rewrite first; a bus write same cycle wins below
		if (exit_edge) begin
			nxt_st.reg_1v2 = exit_rewrite(st_ff.reg_1v2);
			nxt_st.reg_1v0 = exit_rewrite(st_ff.reg_1v0);
		end
		// Only mapped offsets store; holes are acked and dropped
		if (bus_req && wb_we_i) begin
			if (wb_adr_i == RAIL_1V2_OFFSET) begin
				nxt_st.reg_1v2 = merge_byte(st_ff.reg_1v2, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == RAIL_1V0_OFFSET) begin
				nxt_st.reg_1v0 = merge_byte(st_ff.reg_1v0, wb_dat_i, wb_sel_i);
			end
		end
		// Read data taken at the accepting edge, held to next access
		if (bus_req) begin
			if (wb_adr_i == RAIL_1V2_OFFSET) begin
				nxt_st.rdata = {24'h00_0000, st_ff.reg_1v2};
			end else if (wb_adr_i == RAIL_1V0_OFFSET) begin
				nxt_st.rdata = {24'h00_0000, st_ff.reg_1v0};
			end else begin
				nxt_st.rdata = UNMAPPED_READ;
			end
		end
	end

	// Reset loads documented values; synchroniser parks deasserted
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff.reg_1v2   <= RAIL_1V2_RESET;
			st_ff.reg_1v0   <= RAIL_1V0_RESET;
			st_ff.stby_meta <= 1'b1;
			st_ff.stby_sync <= 1'b1;
			st_ff.stby_prev <= 1'b1;
			st_ff.ack       <= 1'b0;
			st_ff.rdata     <= 32'h0000_0000;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Rail outputs
	// ****************************************
	// Outputs are decoded from registered state only
	always_comb begin
		rail_1v2_o.mode      = decode_mode(st_ff.reg_1v2[MODE_LSB+:2]);
		rail_1v0_o.mode      = decode_mode(st_ff.reg_1v0[MODE_LSB+:2]);
		rail_1v2_o.low_power = in_standby & st_ff.reg_1v2[V12_LP_BIT];
		rail_1v0_o.low_power = in_standby & (st_ff.reg_1v0[V10_LP_LSB+:2] != 2'b00);
		// Reduced point only while standby held, else normal
		if (rail_1v2_o.low_power) begin
			rail_1v2_o.trim = -8'sd30;
		end else begin
			rail_1v2_o.trim = trim_1v2(st_ff.reg_1v2[VSEL_LSB+:3]);
		end
		// Reduced code picks the 1.0 V point, 00 falls back to normal
		case (rail_1v0_o.low_power ? st_ff.reg_1v0[V10_LP_LSB+:2] : 2'b00)
			2'b01: rail_1v0_o.trim = -8'sd40;
			2'b10: rail_1v0_o.trim = -8'sd30;
			2'b11: rail_1v0_o.trim = -8'sd20;
			default: rail_1v0_o.trim = trim_1v0(st_ff.reg_1v0[VSEL_LSB+:2]);
		endcase
	end

	assign wb_ack_o = st_ff.ack;
	assign wb_dat_o = st_ff.rdata;

	// ****************************************
	// Checks
	// ****************************************
	// Both registers leave reset at their documented values
	reset_vals_a: assert property (@(posedge clk_i) $past(rst_i) |->
		st_ff.reg_1v2 == 8'h3a && st_ff.reg_1v0 == 8'h1a)
		else $error("reset values wrong");

	// Exit code lands in the 1.2 V mode bits
	exit_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exit_edge && !(bus_req && wb_we_i) && st_ff.reg_1v2[3:2] != 2'b00
		|=> st_ff.reg_1v2[1:0] == $past(st_ff.reg_1v2[3:2]))
		else $error("exit rewrite missed");

	// Exit code 00 leaves the register alone
	exit_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exit_edge && !(bus_req && wb_we_i) && st_ff.reg_1v0[3:2] == 2'b00
		|=> $stable(st_ff.reg_1v0))
		else $error("exit changed mode on 00");

	// Code 00 turns the converter off
	mode_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_ff.reg_1v2[1:0] == 2'b00 |-> rail_1v2_o.mode == CONV_OFF)
		else $error("mode decode wrong");

	// 1.2 V reduced point while standby is held
	lp_1v2_a: assert property (@(posedge clk_i) disable iff (rst_i)
		in_standby && st_ff.reg_1v2[7] |-> rail_1v2_o.trim == -8'sd30)
		else $error("1v2 standby point wrong");

	// 1.0 V lowest reduced point while standby is held
	lp_1v0_a: assert property (@(posedge clk_i) disable iff (rst_i)
		in_standby && st_ff.reg_1v0[7:6] == 2'b01 |-> rail_1v0_o.trim == -8'sd40)
		else $error("1v0 standby point wrong");

	// 1.0 V normal point outside standby
	vsel_1v0_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!in_standby && st_ff.reg_1v0[5:4] == 2'b10 |-> rail_1v0_o.trim == -8'sd25)
		else $error("1v0 set point wrong");

	// 1.2 V bottom step when reduced point is off
	vsel_1v2_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!st_ff.reg_1v2[7] && st_ff.reg_1v2[6:4] == 3'h7 |-> rail_1v2_o.trim == -8'sd40)
		else $error("1v2 set point wrong");

	// Accepted write is stored one edge later
	write_back_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h37
		|=> st_ff.reg_1v0 == $past(wb_dat_i[7:0]))
		else $error("write not stored");

	// A held strobe must not be answered on back-to-back edges
	ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

	// ****************************************
	// Bus protocol checks
	// ****************************************
	// Every accepted request gets its ack one cycle later
	ack_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_req |=> wb_ack_o)
		else $error("request not acknowledged");

	// Holes in the map read as zero but still answer
	unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_req && !wb_we_i && wb_adr_i != 8'h36 && wb_adr_i != 8'h37
		|=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	// Read data is the register as it stood when the request was taken
	read_back_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_req && !wb_we_i && wb_adr_i == 8'h36
		|=> wb_dat_o == {24'h00_0000, $past(st_ff.reg_1v2)})
		else $error("read data wrong");

	// Lane 0 disabled: a write must not touch the register
	sel_guard_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_req && wb_we_i && !wb_sel_i[0] && !exit_edge && wb_adr_i == 8'h36
		|=> $stable(st_ff.reg_1v2))
		else $error("masked write stored");

	// ****************************************
	// Standby checks
	// ****************************************
	// Exit edge seen two clocks after the pin rose, via two flops
	sync_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exit_edge |-> $past(standby_request_n_i, 2) && !$past(standby_request_n_i, 3))
		else $error("standby edge timing wrong");

	// The 1.0 V rail loads its exit code too
	exit_1v0_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exit_edge && !(bus_req && wb_we_i) && st_ff.reg_1v0[3:2] != 2'b00
		|=> st_ff.reg_1v0[1:0] == $past(st_ff.reg_1v0[3:2]))
		else $error("1v0 exit rewrite missed");

	// Out of standby neither rail may show a reduced point
	lp_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!in_standby |-> !rail_1v2_o.low_power && !rail_1v0_o.low_power)
		else $error("low power outside standby");

	// Code 00 keeps the 1.0 V rail at its normal point in standby
	keep_1v0_a: assert property (@(posedge clk_i) disable iff (rst_i)
		in_standby && st_ff.reg_1v0[7:4] == 4'b0001 |-> rail_1v0_o.trim == 8'sd0)
		else $error("1v0 left normal point");

	// ****************************************
	// Mode decode checks
	// ****************************************
	// Both middle codes mean automatic mode
	mode_auto_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_ff.reg_1v2[1:0] == 2'b01 || st_ff.reg_1v2[1:0] == 2'b10
		|-> rail_1v2_o.mode == CONV_AUTO)
		else $error("auto decode wrong");

	// Top code forces PWM
	mode_pwm_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_ff.reg_1v0[1:0] == 2'b11 |-> rail_1v0_o.mode == CONV_PWM)
		else $error("pwm decode wrong");

	// ****************************************
	// Scenario covers
	// ****************************************
	exit_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) exit_edge);
	standby_c: cover property (@(posedge clk_i) disable iff (rst_i)
		rail_1v0_o.low_power ##1 !rail_1v0_o.low_power);
	read_c: cover property (@(posedge clk_i) disable iff (rst_i) wb_ack_o && !wb_we_i);
	pwm_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
		rail_1v2_o.mode == CONV_PWM);
	write_c: cover property (@(posedge clk_i) disable iff (rst_i) bus_req && wb_we_i);

endmodule

// ==== buck_rail_mode_voltage_regs_tb.sv ====
`timescale 1ns/1ps
module buck_rail_mode_voltage_regs_tb;
	import rail_regs_pkg::*;
	logic         clk_i, rst_i, cyc, stb, we, ack, sleep, stby_n;
	logic [7:0]   adr;
	logic [3:0]   sel;
	logic [31:0]  wdat, rdat, rd;
	rail_status_t r12, r10;
	int           miscompares, cmp_count, cycles;
	conv_mode_t   modes[4] = '{CONV_OFF, CONV_AUTO, CONV_AUTO, CONV_PWM};
	int           t10[4] = '{50, 0, -25, -50};

	buck_rail_mode_voltage_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .standby_request_n_i(stby_n),
		.rail_1v2_o(r12), .rail_1v0_o(r10));
	standby_pin_model pm (.clk_i(clk_i), .sleep_i(sleep), .standby_request_n_o(stby_n));

	// ****************************************
	// Helpers
	// ****************************************
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Classic cycle; request held until ack is seen at a rising edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		check(nm, rd, e);
	endtask

	task tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ****************************************
	// Clock and hang guard
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// Whole run is about 120 cycles; far above that means a lost ack
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			tally_and_finish;
		end
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, sleep} = 4'h0;
		adr = 8'h00;
		sel = 4'h1;
		wdat = 32'h0000_0000;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk("reg_1v2", 8'h36, 32'h0000_003a);
		rdchk("reg_1v0", 8'h37, 32'h0000_001a);
		rdchk("unmapped", 8'h38, 32'h0000_0000);
		check("mode_1v2", {30'h0, r12.mode}, {30'h0, CONV_AUTO});
		// Exit field 00 here, so only the written mode shows
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 8'h36, {28'h0000_003, 2'b00, 2'(i)});
			check("mode_1v2", {30'h0, r12.mode}, {30'h0, modes[i]});
		end
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, 8'h36, {24'h0, 1'b0, 3'(i), 4'ha});
			rdchk("vsel_1v2", 8'h36, {24'h0, 1'b0, 3'(i), 4'ha});
			check("trim_1v2", {24'h0, r12.trim}, {24'h0, 8'(30 - 10 * i)});
		end
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 8'h37, {24'h0, 2'b00, 2'(i), 4'ha});
			check("trim_1v0", {24'h0, r10.trim}, {24'h0, 8'(t10[i])});
		end
		// Standby: reduced set points, then exit rewrites 1v2 mode only
		bus(1'b1, 8'h36, 32'h0000_008d);
		bus(1'b1, 8'h37, 32'h0000_0043);
		sleep <= 1'b1;
		repeat (5) @(negedge clk_i);
		check("lp_1v2", {24'h0, r12.trim}, 32'h0000_00e2);
		check("lp_1v0", {24'h0, r10.trim}, 32'h0000_00d8);
		check("lpflag_1v2", {31'h0, r12.low_power}, 32'h0000_0001);
		check("lpflag_1v0", {31'h0, r10.low_power}, 32'h0000_0001);
		@(posedge clk_i);
		sleep <= 1'b0;
		repeat (6) @(negedge clk_i);
		check("trim_1v2", {24'h0, r12.trim}, 32'h0000_001e);
		check("trim_1v0", {24'h0, r10.trim}, 32'h0000_0032);
		check("lpoff_1v2", {31'h0, r12.low_power}, 32'h0000_0000);
		rdchk("exit_1v2", 8'h36, 32'h0000_008f);
		rdchk("exit_1v0", 8'h37, 32'h0000_0043);
		check("mode_1v2", {30'h0, r12.mode}, {30'h0, CONV_PWM});
		check("mode_1v0", {30'h0, r10.mode}, {30'h0, CONV_PWM});
		// Lane 0 off: the write is dropped
		sel <= 4'h0;
		bus(1'b1, 8'h36, 32'h0000_0000);
		sel <= 4'h1;
		rdchk("masked_1v2", 8'h36, 32'h0000_008f);
		bus(1'b1, 8'h38, 32'h0000_00ff);
		rdchk("hole_1v0", 8'h37, 32'h0000_0043);
		tally_and_finish;
	end
endmodule

// ==== rail_regs_pkg.sv ====
package rail_regs_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int unsigned ADDR_W           = 8;
	localparam logic [7:0]  RAIL_1V2_OFFSET  = 8'h36;
	localparam logic [7:0]  RAIL_1V0_OFFSET  = 8'h37;
	localparam logic [7:0]  RAIL_1V2_RESET   = 8'h3a;
	localparam logic [7:0]  RAIL_1V0_RESET   = 8'h1a;
	localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int unsigned MODE_LSB         = 0;
	localparam int unsigned EXIT_LSB         = 2;
	localparam int unsigned VSEL_LSB         = 4;
	localparam int unsigned V12_LP_BIT       = 7;
	localparam int unsigned V10_LP_LSB       = 6;

	// Converter operating mode
	typedef enum logic [1:0] {
		CONV_OFF,
		CONV_AUTO,
		CONV_PWM
	} conv_mode_t;

	// Set point encoded as offset from nominal in tenths of a percent
	typedef logic signed [7:0] trim_t;

	// Per-rail outputs travel together
	typedef struct packed {
		conv_mode_t mode;
		trim_t      trim;
		logic       low_power;
	} rail_status_t;

	typedef struct packed {
		logic [7:0]  reg_1v2;
		logic [7:0]  reg_1v0;
		logic        stby_meta;
		logic        stby_sync;
		logic        stby_prev;
		logic        ack;
		logic [31:0] rdata;
	} regs_state_t;

endpackage

// ==== standby_pin_model.sv ====
`timescale 1ns/1ps
// Platform side of the standby pin; moves only just after a clock edge
module standby_pin_model (
	input  wire logic clk_i,
	input  wire logic sleep_i,
	output logic      standby_request_n_o
);
	// Idle high once clocked; reset in the block masks the first cycles
	always @(posedge clk_i) begin
		standby_request_n_o <= ~sleep_i;
	end
endmodule
